//--- pwd_periodic_wakeup_divider.sv
// Purpose: Periodic wakeup timer front end with AXI4-Lite registers
// Assumes: CLK 25 MHz; RST is power-on reset; SOFT_RST is any other reset, synchronous level
// Notes:   Oscillator tick is derived by divider as a one-cycle enable
`timescale 1ns/1ps
`include "pwd_defines.svh"

module pwd_periodic_wakeup_divider
  import pwd_pkg::*;
#(
  parameter int LFO_TICK_CYCLES = `PWD_LFO_TICK_CYC
)
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        SOFT_RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             WAKE_IRQ,
  output logic             PERIODIC_RST_REQ
);

  localparam int TW = $clog2(LFO_TICK_CYCLES);

  // Register state
  logic [5:0]  prescale_field_q;
  logic [5:0]  wakeup_interval_field_q;
  logic [5:0]  periodic_reset_interval_field_q;
  logic        wakeup_flag_q;
  logic        prst_flag_q;
  logic [1:0]  irq_mask_q;

  // Timing state
  logic [TW-1:0] tick_cnt_q;
  logic          tick_q;
  logic [10:0]   pre_cnt_q;
  logic          wclk_q;
  logic [5:0]    wake_cnt_q;
  logic [5:0]    prst_cnt_q;
  logic          wake_evt_q;
  logic          prst_evt_q;

  // Bus state
  logic        aw_have_q;
  logic [7:0]  aw_addr_q;
  logic        w_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  // Combinational helpers
  pwd_sel_t    wr_sel;
  pwd_sel_t    rd_sel;
  logic        wr_fire;
  logic        wr_low;
  logic [5:0]  wr_field;
  logic        wut_wr;
  logic        prst_wr;
  logic        wut_restart;
  logic        prst_restart;
  logic [10:0] pre_limit;
  logic        ack_wake;
  logic        ack_prst;
  logic [31:0] rd_word;

  // Address decode into register selector
  function automatic pwd_sel_t decode(input logic [7:0] a);
    unique case (a)
      `PWD_OFS_PRESCALE: decode = PWD_SEL_PRESCALE;
      `PWD_OFS_WAKE_CS:  decode = PWD_SEL_WAKE_CS;
      `PWD_OFS_PRST:     decode = PWD_SEL_PRST;
      `PWD_OFS_IRQ_STAT: decode = PWD_SEL_STAT;
      `PWD_OFS_IRQ_MASK: decode = PWD_SEL_MASK;
      default:           decode = PWD_SEL_NONE;
    endcase
  endfunction

  // Write decode and interlock between the two interval fields
  always_comb
  begin
    wr_sel       = decode(aw_addr_q);
    wr_fire      = aw_have_q && w_have_q && !S_AXI_BVALID;
    wr_low       = wr_fire && w_strb_q[0];
    wr_field     = w_data_q[`PWD_FLD_MSB:0];
    wut_wr       = wr_low && (wr_sel == PWD_SEL_WAKE_CS) && (wr_field != wakeup_interval_field_q)
                   && !((wr_field == 6'h00) && (periodic_reset_interval_field_q == 6'h00));
    prst_wr      = wr_low && (wr_sel == PWD_SEL_PRST) && (wr_field != periodic_reset_interval_field_q)
                   && !((wr_field == 6'h00) && (wakeup_interval_field_q == 6'h00));
    wut_restart  = wut_wr;
    prst_restart = prst_wr;
    ack_wake     = (wr_low && (wr_sel == PWD_SEL_WAKE_CS) && w_data_q[`PWD_WACK_BIT])
                   || (wr_low && (wr_sel == PWD_SEL_STAT) && w_data_q[`PWD_ST_WAKE_BIT]);
    ack_prst     = wr_low && (wr_sel == PWD_SEL_STAT) && w_data_q[`PWD_ST_PRST_BIT];
    pre_limit    = `PWD_DIV_BASE + {1'b0, prescale_field_q, 4'h0};
  end

  // Write address channel: hold one address until the write completes
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      S_AXI_AWREADY <= 1'b1;
    end
    else if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      aw_have_q     <= 1'b1;
      aw_addr_q     <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end
    else if (S_AXI_BVALID && S_AXI_BREADY)
    begin
      aw_have_q     <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
    end
  end

  // Write data channel: hold one beat until the write completes
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      w_have_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      S_AXI_WREADY <= 1'b1;
    end
    else if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      w_have_q     <= 1'b1;
      w_data_q     <= S_AXI_WDATA;
      w_strb_q     <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end
    else if (S_AXI_BVALID && S_AXI_BREADY)
    begin
      w_have_q     <= 1'b0;
      S_AXI_WREADY <= 1'b1;
    end
  end

  // Write response once both halves are held
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `PWD_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= (wr_sel == PWD_SEL_NONE) ? `PWD_RESP_SLVERR : `PWD_RESP_OKAY;
    end
    else if (S_AXI_BREADY)
    begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Prescale register: only power-on reset touches it
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      prescale_field_q <= `PWD_PRESCALE_RST;
    else if (wut_wr && (wr_field == 6'h00))
      prescale_field_q <= `PWD_FORCED_DIV;
    else if (wr_low && (wr_sel == PWD_SEL_PRESCALE))
      prescale_field_q <= wr_field;
  end

  // Interval fields, preset by every reset
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      wakeup_interval_field_q         <= `PWD_INTERVAL_RST;
      periodic_reset_interval_field_q <= `PWD_INTERVAL_RST;
    end
    else if (SOFT_RST)
    begin
      wakeup_interval_field_q         <= `PWD_INTERVAL_RST;
      periodic_reset_interval_field_q <= `PWD_INTERVAL_RST;
    end
    else
    begin
      if (wut_wr)
        wakeup_interval_field_q <= wr_field;
      if (prst_wr)
        periodic_reset_interval_field_q <= wr_field;
    end
  end

  // Interrupt mask
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      irq_mask_q <= `PWD_MASK_RST;
    else if (wr_low && (wr_sel == PWD_SEL_MASK))
      irq_mask_q <= w_data_q[1:0];
  end

  // One millisecond oscillator tick from the system clock
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q == TW'(LFO_TICK_CYCLES - 1))
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q     <= 1'b0;
    end
  end

  // Prescaler: one wakeup clock pulse per programmed number of ticks
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pre_cnt_q <= 11'h000;
      wclk_q    <= 1'b0;
    end
    else if (SOFT_RST || wut_restart)
    begin
      pre_cnt_q <= 11'h000;
      wclk_q    <= 1'b0;
    end
    else if (tick_q && (pre_cnt_q >= pre_limit - 11'h001))
    begin
      pre_cnt_q <= 11'h000;
      wclk_q    <= 1'b1;
    end
    else
    begin
      pre_cnt_q <= pre_cnt_q + {10'h000, tick_q};
      wclk_q    <= 1'b0;
    end
  end

  // Wakeup counter: a zero interval lets it wrap at 64 so the reset chain keeps a clock
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      wake_cnt_q <= 6'h00;
      wake_evt_q <= 1'b0;
    end
    else if (SOFT_RST || wut_restart)
    begin
      wake_cnt_q <= 6'h00;
      wake_evt_q <= 1'b0;
    end
    else if (wclk_q && (wake_cnt_q + 6'h01 == wakeup_interval_field_q))
    begin
      wake_cnt_q <= 6'h00;
      wake_evt_q <= 1'b1;
    end
    else
    begin
      wake_cnt_q <= wake_cnt_q + {5'h00, wclk_q};
      wake_evt_q <= wclk_q && (wake_cnt_q == 6'h3f);
    end
  end

  // Periodic reset counter clocked by wakeup events
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      prst_cnt_q <= 6'h00;
      prst_evt_q <= 1'b0;
    end
    else if (SOFT_RST || prst_restart)
    begin
      prst_cnt_q <= 6'h00;
      prst_evt_q <= 1'b0;
    end
    else if (wake_evt_q && (periodic_reset_interval_field_q != 6'h00)
             && (prst_cnt_q + 6'h01 == periodic_reset_interval_field_q))
    begin
      prst_cnt_q <= 6'h00;
      prst_evt_q <= 1'b1;
    end
    else
    begin
      prst_cnt_q <= prst_cnt_q + {5'h00, wake_evt_q && (periodic_reset_interval_field_q != 6'h00)};
      prst_evt_q <= 1'b0;
    end
  end

  // Wakeup flag: set wins over acknowledge; suppressed by a coincident periodic reset
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      wakeup_flag_q <= 1'b0;
    else if (SOFT_RST)
      wakeup_flag_q <= 1'b0;
    else if (wake_evt_q && (wakeup_interval_field_q != 6'h00)
             && !(periodic_reset_interval_field_q != 6'h00
                  && prst_cnt_q + 6'h01 == periodic_reset_interval_field_q))
      wakeup_flag_q <= 1'b1;
    else if (ack_wake)
      wakeup_flag_q <= 1'b0;
  end

  // Periodic reset sticky flag, kept through soft resets
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      prst_flag_q <= 1'b0;
    else if (prst_evt_q)
      prst_flag_q <= 1'b1;
    else if (ack_prst)
      prst_flag_q <= 1'b0;
  end

  // Registered outputs toward the rest of the chip
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      WAKE_IRQ         <= 1'b0;
      PERIODIC_RST_REQ <= 1'b0;
    end
    else
    begin
      WAKE_IRQ         <= |({prst_flag_q, wakeup_flag_q} & irq_mask_q);
      PERIODIC_RST_REQ <= prst_evt_q;
    end
  end

  // Read data mux; acknowledge and unused bits read zero
  always_comb
  begin
    rd_sel  = decode(S_AXI_ARADDR);
    rd_word = 32'h0000_0000;
    unique case (rd_sel)
      PWD_SEL_PRESCALE: rd_word[5:0] = prescale_field_q;
      PWD_SEL_WAKE_CS:  rd_word[7:0] = {wakeup_flag_q, 1'b0, wakeup_interval_field_q};
      PWD_SEL_PRST:     rd_word[5:0] = periodic_reset_interval_field_q;
      PWD_SEL_STAT:     rd_word[1:0] = {prst_flag_q, wakeup_flag_q};
      PWD_SEL_MASK:     rd_word[1:0] = irq_mask_q;
      PWD_SEL_NONE:     rd_word      = 32'h0000_0000;
    endcase
  end

  // Read channel: one read in flight
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `PWD_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_word;
      S_AXI_RRESP   <= (rd_sel == PWD_SEL_NONE) ? `PWD_RESP_SLVERR : `PWD_RESP_OKAY;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
    end
  end

endmodule

//--- pwd_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the wakeup divider
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Included by the design file by bare name
`ifndef PWD_DEFINES_SVH
`define PWD_DEFINES_SVH

// Register byte offsets
`define PWD_OFS_PRESCALE   8'h00
`define PWD_OFS_WAKE_CS    8'h04
`define PWD_OFS_PRST       8'h08
`define PWD_OFS_IRQ_STAT   8'h0c
`define PWD_OFS_IRQ_MASK   8'h10

// Field positions
`define PWD_FLD_MSB        5
`define PWD_WFLAG_BIT      7
`define PWD_WACK_BIT       6
`define PWD_ST_WAKE_BIT    0
`define PWD_ST_PRST_BIT    1

// Reset values and the divider forced by a zero wakeup interval
`define PWD_PRESCALE_RST   6'h1f
`define PWD_INTERVAL_RST   6'h3f
`define PWD_FORCED_DIV     6'h3f
`define PWD_MASK_RST       2'h3

// Prescaler figures: period = base + step * field oscillator ticks
`define PWD_DIV_BASE       11'h1f8
`define PWD_DIV_STEP_SHIFT 4

// Timing: oscillator tick period and system clock period in ns
`define PWD_LFO_PERIOD_NS  1000000
`define PWD_CLK_PERIOD_NS  40
`define PWD_LFO_TICK_CYC   (`PWD_LFO_PERIOD_NS / `PWD_CLK_PERIOD_NS)

// Bus answers
`define PWD_RESP_OKAY      2'h0
`define PWD_RESP_SLVERR    2'h2

`endif

//--- pwd_pkg.sv
// Purpose: Types shared by the wakeup divider design
// Assumes: Constants live in pwd_defines.svh
// Notes:   Register selector decoded from the bus address
package pwd_pkg;

  // Decoded register selector
  typedef enum logic [2:0]
  {
    PWD_SEL_PRESCALE = 3'b000,
    PWD_SEL_WAKE_CS  = 3'b001,
    PWD_SEL_PRST     = 3'b010,
    PWD_SEL_STAT     = 3'b011,
    PWD_SEL_MASK     = 3'b100,
    PWD_SEL_NONE     = 3'b111
  } pwd_sel_t;

endpackage

//--- pwd_periodic_wakeup_divider_assertions.sv
// Purpose: Port-level checks on the wakeup divider
// Assumes: One clock, RST async active high
// Notes:   Bound to the design top below
`timescale 1ns/1ps

module pwd_checker
(
  input logic        CLK,
  input logic        RST,
  input logic        SOFT_RST,
  input logic [7:0]  S_AXI_ARADDR,
  input logic        S_AXI_ARVALID,
  input logic        S_AXI_ARREADY,
  input logic [31:0] S_AXI_RDATA,
  input logic [1:0]  S_AXI_RRESP,
  input logic        S_AXI_RVALID,
  input logic        S_AXI_RREADY,
  input logic        S_AXI_AWVALID,
  input logic        S_AXI_AWREADY,
  input logic        S_AXI_WVALID,
  input logic        S_AXI_WREADY,
  input logic        S_AXI_BVALID,
  input logic        WAKE_IRQ,
  input logic        PERIODIC_RST_REQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // Handshakes that start a read or a write
  sequence s_rd;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence s_wr;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence

  // Bus answers and read data
  property p_rd_lat;
    s_rd |=> S_AXI_RVALID && !S_AXI_ARREADY;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat;
    s_wr |-> ##[1:2] S_AXI_BVALID;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_unmap;
    s_rd ##0 S_AXI_ARADDR > 8'h10 |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  property p_upper;
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits not zero");
  property p_ack0;
    s_rd ##0 S_AXI_ARADDR == 8'h04 |=> !S_AXI_RDATA[6];
  endproperty
  a_ack0: assert property (p_ack0) else $error("ack bit reads one");
  property p_div_unused;
    s_rd ##0 S_AXI_ARADDR == 8'h00 |=> S_AXI_RDATA[7:6] == 2'h0;
  endproperty
  a_div_unused: assert property (p_div_unused) else $error("prescale top bits set");

  // Timer outputs
  property p_pulse;
    PERIODIC_RST_REQ |=> !PERIODIC_RST_REQ [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset request too long");
  property p_irq_fall;
    $fell(WAKE_IRQ) |-> $past(S_AXI_BVALID) || $past(SOFT_RST) || $past(SOFT_RST, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule

bind pwd_periodic_wakeup_divider pwd_checker i_chk
(
  .CLK(CLK), .RST(RST), .SOFT_RST(SOFT_RST), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .WAKE_IRQ(WAKE_IRQ),
  .PERIODIC_RST_REQ(PERIODIC_RST_REQ)
);

//--- pwd_periodic_wakeup_divider_tb.sv
// Purpose: Self-checking bench for the wakeup divider
// Assumes: Oscillator tick shortened to TK clocks
// Notes:   Bus tasks do one AXI4-Lite transfer at a time
`timescale 1ns/1ps
`include "pwd_defines.svh"

module pwd_periodic_wakeup_divider_tb;
  localparam int TK = 2;
  logic        clk, rst, soft_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, prq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  wstrb;
  logic        slow_r;
  int          mismatches, comparisons, cyc, t0;

  pwd_periodic_wakeup_divider #(.LFO_TICK_CYCLES(TK)) i_dut
  (
    .CLK(clk), .RST(rst), .SOFT_RST(soft_rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .WAKE_IRQ(irq),
    .PERIODIC_RST_REQ(prq)
  );

  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  // Bus read; slow_r keeps rready low until the data is offered, so it must stand
  task automatic rdreg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow_r;
    forever
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    rdreg(a, rd, rs);
    chk(rd, e, m);
  endtask

  // Reset values, unused bits, unmapped place
  task automatic t_reset;
    rchk(`PWD_OFS_PRESCALE, 32'h1f, "prescale rst");
    rchk(`PWD_OFS_WAKE_CS, 32'h3f, "wake rst");
    rchk(`PWD_OFS_IRQ_STAT, 32'h0, "stat rst");
    slow_r = 1'b1;
    rchk(`PWD_OFS_IRQ_MASK, 32'h3, "mask rst");
    slow_r = 1'b0;
    wr(`PWD_OFS_PRESCALE, 32'hff, rs);
    rchk(`PWD_OFS_PRESCALE, 32'h3f, "prescale width");
    wstrb <= 4'h0;
    wr(`PWD_OFS_PRESCALE, 32'h01, rs);
    wstrb <= 4'hf;
    chk(32'(rs), 32'(`PWD_RESP_OKAY), "strobe off resp");
    rchk(`PWD_OFS_PRESCALE, 32'h3f, "strobe off kept");
    rdreg(8'h40, rd, rs);
    chk(32'(rs), 32'(`PWD_RESP_SLVERR), "unmapped read");
    wr(8'h40, 32'h1, rs);
    chk(32'(rs), 32'(`PWD_RESP_SLVERR), "unmapped write");
    $display("reset test done");
  endtask

  // Periodic reset on every second wakeup clock, wakeup flag suppressed
  task automatic t_periodic;
    int n;
    wr(`PWD_OFS_IRQ_MASK, 32'h1, rs);
    wr(`PWD_OFS_PRESCALE, 32'h1, rs);
    wr(`PWD_OFS_PRST, 32'h1, rs);
    wr(`PWD_OFS_WAKE_CS, 32'h2, rs);
    while (prq !== 1'b1) @(posedge clk);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prq !== 1'b1);
    chk(n, (504 + 16) * TK * 2, "reset spacing");
    chk(32'(irq), 32'h0, "irq on reset");
    rchk(`PWD_OFS_IRQ_STAT, 32'h2, "flags on reset");
    wr(`PWD_OFS_IRQ_STAT, 32'h2, rs);
    wr(`PWD_OFS_PRST, 32'h3f, rs);
    wr(`PWD_OFS_IRQ_MASK, 32'h3, rs);
    $display("periodic test done");
  endtask

  // Wakeup flag, mask, acknowledge and period
  task automatic t_wake;
    wr(`PWD_OFS_PRESCALE, 32'h0, rs);
    wr(`PWD_OFS_WAKE_CS, 32'h1, rs);
    while (irq !== 1'b1) @(posedge clk);
    t0 = cyc;
    rchk(`PWD_OFS_WAKE_CS, 32'h81, "flag set");
    wr(`PWD_OFS_WAKE_CS, 32'h01, rs);
    rchk(`PWD_OFS_WAKE_CS, 32'h81, "zero ack");
    wr(`PWD_OFS_IRQ_MASK, 32'h0, rs);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0, "masked irq");
    wr(`PWD_OFS_IRQ_MASK, 32'h1, rs);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1, "unmasked irq");
    wr(`PWD_OFS_WAKE_CS, 32'h41, rs);
    rchk(`PWD_OFS_WAKE_CS, 32'h01, "ack clears");
    chk(32'(irq), 32'h0, "irq after ack");
    while (irq !== 1'b1) @(posedge clk);
    chk(cyc - t0, 504 * TK, "wake period");
    wr(`PWD_OFS_IRQ_STAT, 32'h1, rs);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0, "status clear");
    $display("wake test done");
  endtask

  // Interlock between the two interval fields
  task automatic t_lock;
    wr(`PWD_OFS_PRESCALE, 32'h5, rs);
    wr(`PWD_OFS_PRST, 32'h0, rs);
    rchk(`PWD_OFS_PRST, 32'h0, "prst cleared");
    wr(`PWD_OFS_WAKE_CS, 32'h0, rs);
    rchk(`PWD_OFS_WAKE_CS, 32'h1, "wake kept");
    wr(`PWD_OFS_PRST, 32'h5, rs);
    wr(`PWD_OFS_WAKE_CS, 32'h0, rs);
    rchk(`PWD_OFS_WAKE_CS, 32'h0, "wake cleared");
    rchk(`PWD_OFS_PRESCALE, 32'h3f, "forced divider");
    wr(`PWD_OFS_PRST, 32'h0, rs);
    rchk(`PWD_OFS_PRST, 32'h5, "prst kept");
    $display("interlock test done");
  endtask

  // Other reset keeps the prescale field, presets the intervals and clears the flag
  task automatic t_soft;
    wr(`PWD_OFS_PRESCALE, 32'h5, rs);
    wr(`PWD_OFS_WAKE_CS, 32'h01, rs);
    while (irq !== 1'b1) @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    rchk(`PWD_OFS_PRESCALE, 32'h5, "prescale kept");
    rchk(`PWD_OFS_WAKE_CS, 32'h3f, "wake preset");
    rchk(`PWD_OFS_PRST, 32'h3f, "prst preset");
    chk(32'(irq), 32'h0, "irq after reset");
    $display("soft reset test done");
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Cycle count and hang limit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      mismatches++;
      $display("BAD %0t timeout", $time);
      end_of_test;
    end
  end

  // Main sequence
  initial
  begin
    {rst, soft_rst, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    slow_r = 1'b0;
    {mismatches, comparisons, cyc} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_periodic;
    t_wake;
    t_lock;
    t_soft;
    end_of_test;
  end
endmodule
